// [dsp_ctl_consts.svh]
`ifndef DSP_CTL_CONSTS_SVH
`define DSP_CTL_CONSTS_SVH

// ****************************************
// Register addresses
// ****************************************
`define DRAM_FIRST_ADDR   16'h4380
`define DRAM_LAST_ADDR    16'h43BE
`define PROT_KEY_ADDR     16'hE7FE
`define PROT_CTRL_ADDR    16'hE7E3
`define RUN_ADDR          16'hE000
`define FIRST_STATUS_REGISTER_ADDR      16'hE004
`define FIRST_MASK_REGISTER_ADDR        16'hE008
`define SECOND_CONFIG_REGISTER_ADDR      16'hE00C
`define CAL_A_ADDR        16'hE010
`define CAL_B_ADDR        16'hE014
`define CAL_C_ADDR        16'hE018

// ****************************************
// Field values and positions
// ****************************************
`define PROT_KEY_VAL      8'hAD
`define PROT_ON_VAL       8'h80
`define PROT_OFF_VAL      8'h00
`define RUN_START_VAL     16'h0001
`define RUN_RESET_VAL     16'h0000
`define DONE_BIT          17
`define EXTREF_BIT        0
`define CAL_W             10
`define CAL_DELAY_BIT     9
`define DRAM_W            28
`define DRAM_WORDS        63
`define DRAM_IDX_W        6

// ****************************************
// Timing
// ****************************************
`define CLK_KHZ           200000
`define STEP_KHZ          1024
`define SAMPLE_KHZ        8
`define STEPS_PER_SAMPLE  (`STEP_KHZ / `SAMPLE_KHZ)
`define DSP_PASS_CYC      16'd600

`endif

// [dsp_ctl_pkg.sv]
package dsp_ctl_pkg;

  typedef enum logic [1:0] {
    DSP_IDLE = 2'b00,
    DSP_WAIT = 2'b01,
    DSP_BUSY = 2'b10
  } dsp_state_t;

endpackage : dsp_ctl_pkg

// [dsp_timebase.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dsp_ctl_consts.svh"

module dsp_timebase (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic soft_reset_in,
  output var  logic step_tick_out,
  output var  logic sample_tick_out
);

  // ****************************************
  // Fractional divider, 200 MHz to 1.024 MHz
  // ****************************************
  // Non-integer ratio, so a phase accumulator keeps long-term rate exact
  logic [17:0] acc_ff;
  logic [17:0] nxt_acc;
  logic        nxt_step;
  logic [6:0]  step_cnt_ff;

  always_comb begin
    nxt_acc  = acc_ff + 18'(`STEP_KHZ);
    nxt_step = 1'b0;
    if (nxt_acc >= 18'(`CLK_KHZ)) begin
      nxt_acc  = nxt_acc - 18'(`CLK_KHZ);
      nxt_step = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_ff        <= 18'h00000;
      step_tick_out <= 1'b0;
    end else if (soft_reset_in) begin
      acc_ff        <= 18'h00000;
      step_tick_out <= 1'b0;
    end else begin
      acc_ff        <= nxt_acc;
      step_tick_out <= nxt_step;
    end
  end

  // ****************************************
  // Sample period, 128 steps
  // ****************************************
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      step_cnt_ff     <= 7'h00;
      sample_tick_out <= 1'b0;
    end else if (soft_reset_in) begin
      step_cnt_ff     <= 7'h00;
      sample_tick_out <= 1'b0;
    end else begin
      sample_tick_out <= 1'b0;
      if (nxt_step) begin
        step_cnt_ff <= step_cnt_ff + 7'h01;
        if (step_cnt_ff == 7'(`STEPS_PER_SAMPLE - 1)) begin
          step_cnt_ff     <= 7'h00;
          sample_tick_out <= 1'b1;
        end
      end
    end
  end

endmodule : dsp_timebase
`default_nettype wire

// [dsp_run_protect_phase_cal.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dsp_ctl_consts.svh"

module dsp_run_protect_phase_cal
  import dsp_ctl_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        soft_reset_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [15:0] reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  output var  logic [31:0] reg_rdata_out,
  output var  logic        reg_rvalid_out,
  output var  logic        first_interrupt_output_n_out,
  output var  logic        dsp_running_out,
  output var  logic        dsp_pass_done_out,
  output var  logic        protect_on_out,
  output var  logic        ext_ref_sel_out,
  output wire logic        shift_step_out,
  output var  logic [9:0]  volt_shift_a_out,
  output var  logic [9:0]  volt_shift_b_out,
  output var  logic [9:0]  volt_shift_c_out
);

  // ****************************************
  // Decode helpers
  // ****************************************
  function automatic logic in_dram(input logic [15:0] addr);
    in_dram = (addr >= `DRAM_FIRST_ADDR) && (addr <= `DRAM_LAST_ADDR);
  endfunction : in_dram

  function automatic logic [`DRAM_IDX_W-1:0] dram_idx(input logic [15:0] addr);
    logic [15:0] off;
    off      = addr - `DRAM_FIRST_ADDR;
    dram_idx = off[`DRAM_IDX_W-1:0];
  endfunction : dram_idx

  // Signed step count: bit 9 set means delay of low bits, else advance
  function automatic logic [9:0] cal_to_shift(input logic [`CAL_W-1:0] cal);
    if (cal[`CAL_DELAY_BIT]) begin
      cal_to_shift = {1'b0, cal[8:0]};
    end else begin
      cal_to_shift = 10'h000 - {1'b0, cal[8:0]};
    end
  endfunction : cal_to_shift

  // ****************************************
  // Time base
  // ****************************************
  logic sample_tick;

  dsp_timebase u_timebase (
    .clk_in          (clk_in),
    .arst_n_in       (arst_n_in),
    .soft_reset_in   (soft_reset_in),
    .step_tick_out   (shift_step_out),
    .sample_tick_out (sample_tick)
  );

  // ****************************************
  // Write decode
  // ****************************************
  logic wr_dram;
  logic wr_key;
  logic wr_ctrl;
  logic wr_run;
  logic wr_first_status_register;
  logic wr_first_mask_register;
  logic wr_second_config_register;
  logic [2:0] wr_cal;

  always_comb begin
    wr_dram    = reg_wr_in && in_dram(reg_addr_in);
    wr_key     = reg_wr_in && (reg_addr_in == `PROT_KEY_ADDR);
    wr_ctrl    = reg_wr_in && (reg_addr_in == `PROT_CTRL_ADDR);
    wr_run     = reg_wr_in && (reg_addr_in == `RUN_ADDR);
    wr_first_status_register = reg_wr_in && (reg_addr_in == `FIRST_STATUS_REGISTER_ADDR);
    wr_first_mask_register   = reg_wr_in && (reg_addr_in == `FIRST_MASK_REGISTER_ADDR);
    wr_second_config_register = reg_wr_in && (reg_addr_in == `SECOND_CONFIG_REGISTER_ADDR);
    wr_cal[0]  = reg_wr_in && (reg_addr_in == `CAL_A_ADDR);
    wr_cal[1]  = reg_wr_in && (reg_addr_in == `CAL_B_ADDR);
    wr_cal[2]  = reg_wr_in && (reg_addr_in == `CAL_C_ADDR);
  end

  // ****************************************
  // Write protection
  // ****************************************
  logic key_armed_ff;

  // Key must be the write just before the control write
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      key_armed_ff   <= 1'b0;
      protect_on_out <= 1'b0;
    end else if (soft_reset_in) begin
      key_armed_ff   <= 1'b0;
      protect_on_out <= 1'b0;
    end else if (reg_wr_in) begin
      key_armed_ff <= wr_key && (reg_wdata_in[7:0] == `PROT_KEY_VAL);
      if (wr_ctrl && key_armed_ff) begin
        if (reg_wdata_in[7:0] == `PROT_ON_VAL) begin
          protect_on_out <= 1'b1;
        end else if (reg_wdata_in[7:0] == `PROT_OFF_VAL) begin
          protect_on_out <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Data RAM and write pipeline
  // ****************************************
  logic [`DRAM_W-1:0]     dram_ff [`DRAM_WORDS];
  logic [1:0]             pipe_vld_ff;
  logic [`DRAM_IDX_W-1:0] pipe_idx_ff [2];
  logic [`DRAM_W-1:0]     pipe_dat_ff [2];
  logic                   dram_accept;

  // Protected writes never enter the pipe, though like any write they still disarm the protection key
  assign dram_accept = wr_dram && !protect_on_out;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pipe_vld_ff <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        pipe_idx_ff[i] <= 6'h00;
        pipe_dat_ff[i] <= 28'h0000000;
      end
    end else if (soft_reset_in) begin
      pipe_vld_ff <= 2'b00;
      for (int i = 0; i < 2; i++) begin
        pipe_idx_ff[i] <= 6'h00;
        pipe_dat_ff[i] <= 28'h0000000;
      end
    end else if (dram_accept) begin
      pipe_vld_ff    <= {pipe_vld_ff[0], 1'b1};
      pipe_idx_ff[0] <= dram_idx(reg_addr_in);
      pipe_dat_ff[0] <= reg_wdata_in[`DRAM_W-1:0];
      pipe_idx_ff[1] <= pipe_idx_ff[0];
      pipe_dat_ff[1] <= pipe_dat_ff[0];
    end
  end

  // Only the oldest stage commits, pushed out by a later accepted write
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i < `DRAM_WORDS; i++) begin
        dram_ff[i] <= 28'h0000000;
      end
    end else if (soft_reset_in) begin
      for (int i = 0; i < `DRAM_WORDS; i++) begin
        dram_ff[i] <= 28'h0000000;
      end
    end else if (dram_accept && pipe_vld_ff[1]) begin
      dram_ff[pipe_idx_ff[1]] <= pipe_dat_ff[1];
    end
  end

  // ****************************************
  // Phase calibration
  // ****************************************
  logic [`CAL_W-1:0] cal_ff [3];
  logic [9:0]        shift_ff [3];

  for (genvar g = 0; g < 3; g++) begin : g_cal
    always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        cal_ff[g]   <= 10'h000;
        shift_ff[g] <= 10'h000;
      end else if (soft_reset_in) begin
        cal_ff[g]   <= 10'h000;
        shift_ff[g] <= 10'h000;
      end else begin
        if (wr_cal[g]) begin
          cal_ff[g] <= reg_wdata_in[`CAL_W-1:0];
        end
        shift_ff[g] <= cal_to_shift(cal_ff[g]);
      end
    end
  end

  // Counts are in shift_step_out periods
  assign volt_shift_a_out = shift_ff[0];
  assign volt_shift_b_out = shift_ff[1];
  assign volt_shift_c_out = shift_ff[2];

  // ****************************************
  // Config, run and mask registers
  // ****************************************
  logic [15:0] run_ff;
  logic [31:0] first_mask_register_ff;

  // No power-mode input touches this, so it survives every mode
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ext_ref_sel_out <= 1'b0;
    end else if (soft_reset_in) begin
      ext_ref_sel_out <= 1'b0;
    end else if (wr_second_config_register) begin
      ext_ref_sel_out <= reg_wdata_in[`EXTREF_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      run_ff   <= `RUN_RESET_VAL;
      first_mask_register_ff <= 32'h00000000;
    end else if (soft_reset_in) begin
      run_ff   <= `RUN_RESET_VAL;
      first_mask_register_ff <= 32'h00000000;
    end else begin
      if (wr_run) begin
        run_ff <= reg_wdata_in[15:0];
      end
      if (wr_first_mask_register) begin
        first_mask_register_ff <= reg_wdata_in;
      end
    end
  end

  // ****************************************
  // Processor schedule
  // ****************************************
  dsp_state_t  state_ff;
  logic [15:0] pass_cnt_ff;
  logic        run_req;

  assign run_req = (run_ff == `RUN_START_VAL);

  // Stopping aborts a pass in flight; no done flag for a partial pass
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_ff          <= DSP_IDLE;
      pass_cnt_ff       <= 16'h0000;
      dsp_pass_done_out <= 1'b0;
    end else if (soft_reset_in) begin
      state_ff          <= DSP_IDLE;
      pass_cnt_ff       <= 16'h0000;
      dsp_pass_done_out <= 1'b0;
    end else begin
      dsp_pass_done_out <= 1'b0;
      unique case (state_ff)
        DSP_IDLE: begin
          if (run_req) begin
            state_ff <= DSP_WAIT;
          end
        end
        DSP_WAIT: begin
          if (!run_req) begin
            state_ff <= DSP_IDLE;
          end else if (sample_tick) begin
            state_ff    <= DSP_BUSY;
            pass_cnt_ff <= 16'h0000;
          end
        end
        DSP_BUSY: begin
          pass_cnt_ff <= pass_cnt_ff + 16'h0001;
          if (!run_req) begin
            state_ff <= DSP_IDLE;
          end else if (pass_cnt_ff == `DSP_PASS_CYC - 16'h0001) begin
            state_ff          <= DSP_WAIT;
            dsp_pass_done_out <= 1'b1;
          end
        end
        default: begin
          state_ff <= DSP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dsp_running_out <= 1'b0;
    end else if (soft_reset_in) begin
      dsp_running_out <= 1'b0;
    end else begin
      dsp_running_out <= run_req;
    end
  end

  // ****************************************
  // Done flag and interrupt
  // ****************************************
  logic done_flag_ff;
  logic nxt_done_flag;

  // Set beats clear so a pass ending during the clear is not lost
  always_comb begin
    nxt_done_flag = done_flag_ff;
    if (wr_first_status_register && reg_wdata_in[`DONE_BIT]) begin
      nxt_done_flag = 1'b0;
    end
    if (dsp_pass_done_out) begin
      nxt_done_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_flag_ff <= 1'b0;
      first_interrupt_output_n_out   <= 1'b1;
    end else if (soft_reset_in) begin
      done_flag_ff <= 1'b0;
      first_interrupt_output_n_out   <= 1'b1;
    end else begin
      done_flag_ff <= nxt_done_flag;
      first_interrupt_output_n_out   <= !(nxt_done_flag && first_mask_register_ff[`DONE_BIT]);
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  logic [31:0] rd_mux;

  // Reads ignore protection and show committed RAM, not the pipe
  always_comb begin
    rd_mux = 32'h00000000;
    if (in_dram(reg_addr_in)) begin
      rd_mux = {4'h0, dram_ff[dram_idx(reg_addr_in)]};
    end else begin
      unique case (reg_addr_in)
        `RUN_ADDR:     rd_mux = {16'h0000, run_ff};
        `FIRST_STATUS_REGISTER_ADDR: rd_mux = 32'(done_flag_ff) << `DONE_BIT;
        `FIRST_MASK_REGISTER_ADDR:   rd_mux = first_mask_register_ff;
        `SECOND_CONFIG_REGISTER_ADDR: rd_mux = {31'h00000000, ext_ref_sel_out};
        `CAL_A_ADDR:   rd_mux = {22'h000000, cal_ff[0]};
        `CAL_B_ADDR:   rd_mux = {22'h000000, cal_ff[1]};
        `CAL_C_ADDR:   rd_mux = {22'h000000, cal_ff[2]};
        default:       rd_mux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out  <= 32'h00000000;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rd_mux;
      end
    end
  end

endmodule : dsp_run_protect_phase_cal
`default_nettype wire

// [dsp_run_protect_phase_cal_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dsp_ctl_consts.svh"
module dsp_run_protect_phase_cal_asserts (
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  input wire logic        soft_reset_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_rvalid_out,
  input wire logic        first_interrupt_output_n_out,
  input wire logic        dsp_running_out,
  input wire logic        dsp_pass_done_out,
  input wire logic        protect_on_out,
  input wire logic        ext_ref_sel_out,
  input wire logic        shift_step_out,
  input wire logic [9:0]  volt_shift_a_out
);
  // ****
  // Helper state
  // ****
  logic       mask_ff;
  logic       armed_ff;
  logic       seen_ff;
  logic [7:0] gap_ff;
  logic       wr_cal_a;
  logic       wr_cfg2;
  logic       wr_run;
  logic       wr_stat;
  logic       wr_ctrl;

  // Plain nets, so properties see sampled bus values, not values from inside a function
  assign wr_cal_a = reg_wr_in && (reg_addr_in == `CAL_A_ADDR);
  assign wr_cfg2  = reg_wr_in && (reg_addr_in == `SECOND_CONFIG_REGISTER_ADDR);
  assign wr_run   = reg_wr_in && (reg_addr_in == `RUN_ADDR);
  assign wr_stat  = reg_wr_in && (reg_addr_in == `FIRST_STATUS_REGISTER_ADDR);
  assign wr_ctrl  = reg_wr_in && (reg_addr_in == `PROT_CTRL_ADDR);

  function automatic logic wr_to(input logic [15:0] a);
    return reg_wr_in && reg_addr_in == a;
  endfunction : wr_to

  function automatic logic [9:0] shift_of(input logic [31:0] d);
    return d[9] ? {1'b0, d[8:0]} : 10'h000 - {1'b0, d[8:0]};
  endfunction : shift_of

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in || soft_reset_in) begin
      mask_ff  <= 1'b0;
      armed_ff <= 1'b0;
    end else if (reg_wr_in) begin
      // Any other write between key and control disarms
      armed_ff <= wr_to(`PROT_KEY_ADDR) && reg_wdata_in[7:0] == `PROT_KEY_VAL;
      if (wr_to(`FIRST_MASK_REGISTER_ADDR)) begin
        mask_ff <= reg_wdata_in[`DONE_BIT];
      end
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in || soft_reset_in) begin
      seen_ff <= 1'b0;
      gap_ff  <= 8'h00;
    end else if (shift_step_out) begin
      seen_ff <= 1'b1;
      gap_ff  <= 8'h00;
    end else if (gap_ff != 8'hFF) begin
      gap_ff <= gap_ff + 8'h01;
    end
  end

  // ****
  // Properties
  // ****
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in || soft_reset_in);

  sequence s_ctrl(logic [7:0] v);
    armed_ff && wr_ctrl && reg_wdata_in[7:0] == v;
  endsequence

  a_read_answered: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read not answered");
  a_cal_decode: assert property (wr_cal_a |-> ##2 volt_shift_a_out == shift_of($past(reg_wdata_in, 2)))
    else $error("phase shift wrong");
  a_ext_ref: assert property (wr_cfg2 |=> ext_ref_sel_out == $past(reg_wdata_in[0]))
    else $error("reference select wrong");
  // Run register lands one cycle after the write, the level one cycle later
  a_run_level: assert property (wr_run |-> ##2 dsp_running_out == ($past(reg_wdata_in[15:0], 2) == `RUN_START_VAL))
    else $error("run level wrong");
  a_done_irq: assert property (dsp_pass_done_out && mask_ff |=> !first_interrupt_output_n_out)
    else $error("interrupt not raised");
  a_irq_clear: assert property (wr_stat && reg_wdata_in[`DONE_BIT] && !dsp_pass_done_out |=> first_interrupt_output_n_out)
    else $error("interrupt not cleared");
  a_done_running: assert property (dsp_pass_done_out && !$past(reg_wr_in) |-> dsp_running_out)
    else $error("pass while stopped");
  a_prot_on: assert property (s_ctrl(`PROT_ON_VAL) |=> protect_on_out)
    else $error("protection not on");
  a_prot_off: assert property (s_ctrl(`PROT_OFF_VAL) |=> !protect_on_out)
    else $error("protection not off");
  a_step_gap: assert property (shift_step_out && seen_ff |-> gap_ff inside {8'd194, 8'd195})
    else $error("step spacing wrong");
endmodule : dsp_run_protect_phase_cal_asserts
`default_nettype wire

// [host_port_model.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dsp_ctl_consts.svh"
module host_port_model (
  input  wire logic        clk_in,
  output var  logic        wr_out,
  output var  logic        rd_out,
  output var  logic [15:0] addr_out,
  output var  logic [31:0] wdata_out
);
  // ****
  // Host side of the register port
  // ****
  logic [31:0] exp_q[$];

  initial begin
    wr_out    = 1'b0;
    rd_out    = 1'b0;
    addr_out  = 16'h0000;
    wdata_out = 32'h0000_0000;
  end

  // Strobe drops for a cycle so no signal is set twice at one edge
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
    wr_out    <= 1'b1;
    addr_out  <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    @(posedge clk_in);
  endtask : wr_reg

  task automatic rd_reg(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    rd_out   <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out <= 1'b0;
    @(posedge clk_in);
  endtask : rd_reg

  function automatic logic [15:0] cal_word(input int cnt);
    return cnt <= 0 ? 16'(-cnt) : 16'(cnt + 512);
  endfunction : cal_word

  task automatic set_protect(input logic on);
    wr_reg(`PROT_KEY_ADDR, {24'h000000, `PROT_KEY_VAL});
    wr_reg(`PROT_CTRL_ADDR, {24'h000000, on ? `PROT_ON_VAL : `PROT_OFF_VAL});
  endtask : set_protect

  task automatic ram_flush(input logic [15:0] a, input logic [31:0] d);
    repeat (3) wr_reg(a, d);
  endtask : ram_flush
endmodule : host_port_model
`default_nettype wire

// [tb_dsp_run_protect_phase_cal.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dsp_ctl_consts.svh"
module tb_dsp_run_protect_phase_cal;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        soft_reset_in = 1'b0;
  logic        wr, rd, rvalid, irq_n, running, done, prot, ext_ref, step;
  logic [15:0] addr;
  logic [31:0] wdata, rdata;
  logic [9:0]  sh_a, sh_b, sh_c;
  int          err_count = 0;
  int          num_checks = 0;
  int          seed = 32'h581febcb;

  always #2.5 clk_in = ~clk_in;

  host_port_model host_u (.clk_in(clk_in), .wr_out(wr), .rd_out(rd), .addr_out(addr), .wdata_out(wdata));

  dsp_run_protect_phase_cal dut_u (.clk_in(clk_in), .arst_n_in(arst_n_in), .soft_reset_in(soft_reset_in),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid), .first_interrupt_output_n_out(irq_n), .dsp_running_out(running), .dsp_pass_done_out(done),
    .protect_on_out(prot), .ext_ref_sel_out(ext_ref), .shift_step_out(step), .volt_shift_a_out(sh_a),
    .volt_shift_b_out(sh_b), .volt_shift_c_out(sh_c));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  // ****
  // Read monitor and watchdog
  // ****
  always @(negedge clk_in) begin
    if (rvalid === 1'b1) begin
      check("read data", rdata, host_u.exp_q.pop_front());
    end
  end

  initial begin
    #400000;
    err_count++;
    print_verdict();
  end

  // ****
  // Scenarios
  // ****
  initial begin
    logic [27:0] v1, v2;
    int          cnt[3];
    int          k;
    repeat (16) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(negedge clk_in);
    check("irq", irq_n, 1);
    check("running", running, 0);
    check("protect", {prot, ext_ref}, 0);
    @(posedge clk_in);
    host_u.rd_reg(`RUN_ADDR, 0);
    host_u.rd_reg(`DRAM_LAST_ADDR, 0);
    host_u.rd_reg(`PROT_KEY_ADDR, 0);
    cnt = '{-383, 63, 0};
    cnt[2] = int'($unsigned($random(seed)) % 447) - 383;
    for (int i = 0; i < 3; i++) begin
      host_u.wr_reg(`CAL_A_ADDR + 16'(4 * i), {16'h0000, host_u.cal_word(cnt[i])});
      host_u.rd_reg(`CAL_A_ADDR + 16'(4 * i), {16'h0000, host_u.cal_word(cnt[i])});
    end
    @(negedge clk_in);
    check("shift", {sh_a, sh_b, sh_c}, {2'b00, 10'(cnt[0]), 10'(cnt[1]), 10'(cnt[2])});
    @(posedge clk_in);
    for (int b = 1; b >= 0; b--) begin
      host_u.wr_reg(`SECOND_CONFIG_REGISTER_ADDR, 32'(b));
      host_u.rd_reg(`SECOND_CONFIG_REGISTER_ADDR, 32'(b));
      check("ext ref", ext_ref, 32'(b));
    end
    v1 = 28'($random(seed));
    v2 = 28'($random(seed));
    host_u.wr_reg(`DRAM_FIRST_ADDR, {4'h0, v1});
    host_u.rd_reg(`DRAM_FIRST_ADDR, 0);
    host_u.wr_reg(`DRAM_LAST_ADDR, {4'h0, v2});
    host_u.wr_reg(`DRAM_LAST_ADDR, {4'h0, v2});
    host_u.rd_reg(`DRAM_FIRST_ADDR, {4'h0, v1});
    host_u.rd_reg(`DRAM_LAST_ADDR, 0);
    host_u.wr_reg(`DRAM_LAST_ADDR, {4'h0, v2});
    host_u.rd_reg(`DRAM_LAST_ADDR, {4'h0, v2});
    host_u.set_protect(1'b1);
    check("protect", prot, 1);
    host_u.ram_flush(`DRAM_FIRST_ADDR, {4'h0, ~v1});
    host_u.rd_reg(`DRAM_FIRST_ADDR, {4'h0, v1});
    check("irq", irq_n, 1);
    host_u.wr_reg(`PROT_KEY_ADDR, {24'h000000, `PROT_KEY_VAL});
    host_u.wr_reg(`FIRST_MASK_REGISTER_ADDR, 32'h0002_0000);
    host_u.wr_reg(`PROT_CTRL_ADDR, 32'h0000_0000);
    check("protect", prot, 1);
    host_u.set_protect(1'b0);
    check("protect", prot, 0);
    host_u.wr_reg(`RUN_ADDR, {16'h0000, `RUN_START_VAL});
    // Running level moves at the edge the task returns on
    @(negedge clk_in);
    check("running", running, 1);
    for (k = 0; k < 30000 && done !== 1'b1; k++) @(negedge clk_in);
    check("pass done", done, 1);
    @(negedge clk_in);
    check("irq", irq_n, 0);
    @(posedge clk_in);
    host_u.rd_reg(`FIRST_STATUS_REGISTER_ADDR, 32'h0002_0000);
    host_u.wr_reg(`CAL_B_ADDR, 32'h0000_0205);
    @(negedge clk_in);
    check("shift b", sh_b, 32'h0000_0005);
    @(posedge clk_in);
    host_u.wr_reg(`FIRST_STATUS_REGISTER_ADDR, 32'h0002_0000);
    check("irq", irq_n, 1);
    host_u.set_protect(1'b1);
    soft_reset_in <= 1'b1;
    @(posedge clk_in);
    soft_reset_in <= 1'b0;
    @(negedge clk_in);
    check("after soft reset", {running, prot, sh_a}, 0);
    @(posedge clk_in);
    host_u.rd_reg(`DRAM_FIRST_ADDR, 0);
    host_u.wr_reg(`RUN_ADDR, {16'h0000, `RUN_START_VAL});
    host_u.wr_reg(`RUN_ADDR, {16'h0000, `RUN_RESET_VAL});
    @(negedge clk_in);
    check("running", running, 0);
    repeat (4) @(posedge clk_in);
    print_verdict();
  end
endmodule : tb_dsp_run_protect_phase_cal

bind dsp_run_protect_phase_cal dsp_run_protect_phase_cal_asserts chk_u (.clk_in(clk_in), .arst_n_in(arst_n_in),
  .soft_reset_in(soft_reset_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_rvalid_out(reg_rvalid_out), .first_interrupt_output_n_out(first_interrupt_output_n_out),
  .dsp_running_out(dsp_running_out), .dsp_pass_done_out(dsp_pass_done_out), .protect_on_out(protect_on_out),
  .ext_ref_sel_out(ext_ref_sel_out), .shift_step_out(shift_step_out), .volt_shift_a_out(volt_shift_a_out));
`default_nettype wire
